// File: tb/alq_host.sv
`timescale 1ns/1ps
`default_nettype none

module alq_host (
	// clock
	input  wire logic        clk_i,
	// register strobes toward the device
	output logic             reg_wr_o,
	output logic             reg_rd_o,
	output logic      [7:0]  reg_addr_o,
	output logic      [7:0]  reg_wdata_o,
	// alarm enables
	output logic      [13:0] enable_o
);
	// idle bus parked on no register
	initial begin
		reg_wr_o = 1'b0;
		reg_rd_o = 1'b0;
		reg_addr_o = 8'hff;
		reg_wdata_o = 8'h00;
		enable_o = 14'h0;
	end

	// one-cycle strobe from the falling edge
	task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_i);
		reg_wr_o = wr;
		reg_rd_o = ~wr;
		reg_addr_o = a;
		reg_wdata_o = d;
		@(negedge clk_i);
		reg_wr_o = 1'b0;
		reg_rd_o = 1'b0;
		reg_addr_o = ~a; // released bus shows no stale value
		reg_wdata_o = ~d;
	endtask

	// alarms only route while enabled
	task automatic set_en(input logic [13:0] v);
		@(negedge clk_i);
		enable_o = v;
	endtask
endmodule

`default_nettype wire

// File: tb/alq_top_tb.sv
`timescale 1ns/1ps
`default_nettype none

module alq_top_tb import alq_pkg::*;;
	logic        clk_i = 1'b0;
	logic        reset_n_i;
	logic        sample_valid;
	logic        rd;
	logic        wr;
	logic        rd_pend = 1'b0;
	logic [7:0]  addr;
	logic [7:0]  wdata;
	logic [7:0]  rdata;
	logic [13:0] beyond;
	logic [13:0] en;
	logic [13:0] en_hw;
	wire  logic [13:0] alarm;
	logic [13:0] exp_alarm;
	logic [13:0] prev = 14'h0;
	logic [31:0] lfsr = 32'heb36a9f7;
	logic [13:0] q[$];
	string       qn[$];
	int          run[14];
	int          need[14];
	int          n_errors = 0;
	int          n_tests = 0;

	// clock
	always #50 clk_i = ~clk_i;

	alq_host i_alq_host (.clk_i(clk_i), .reg_wr_o(wr), .reg_rd_o(rd), .reg_addr_o(addr),
		.reg_wdata_o(wdata), .enable_o(en_hw));

	alq_top i_alq_top (.clk_i(clk_i), .reset_n_i(reset_n_i), .reg_wr_i(wr), .reg_rd_i(rd),
		.reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
		.sample_valid_i(sample_valid), .overcurrent_beyond_i(beyond[13:12]),
		.undercurrent_beyond_i(beyond[11:8]), .overpower_beyond_i(beyond[7:4]),
		.overvoltage_beyond_i(beyond[3:0]), .overcurrent_enable_i(en_hw[13:12]),
		.undercurrent_enable_i(en_hw[11:8]), .overpower_enable_i(en_hw[7:4]),
		.overvoltage_enable_i(en_hw[3:0]), .overcurrent_alarm_o(alarm[13:12]),
		.undercurrent_alarm_o(alarm[11:8]), .overpower_alarm_o(alarm[7:4]),
		.overvoltage_alarm_o(alarm[3:0]));

	function automatic logic [31:0] step(input logic [31:0] x);
		return (x >> 1) ^ (x[0] ? 32'h80200003 : 32'h0);
	endfunction

	// field code to run length
	function automatic int dec(input logic [7:0] r, input int c);
		logic [1:0] f;
		f = r[7 - 2 * c -: 2];
		return (f == 2'h0) ? 1 : (4 << (f - 2'h1));
	endfunction

	task automatic check(input string what, input logic [13:0] seen, input logic [13:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic summarize();
		check("pending notes", 14'(q.size()), 14'h0);
		if (n_errors == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// reference alarms; only changes are noted
	task automatic note_alarms();
		logic [13:0] e;
		for (int i = 0; i < 14; i++)
			e[i] = en[i] & (run[i] >= need[i]);
		if (e !== exp_alarm) begin
			q.push_back(e);
			qn.push_back("alarms");
		end
		exp_alarm = e;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		q.push_back({6'h0, e});
		qn.push_back("rdata");
		i_alq_host.access(1'b0, a, 8'h00);
	endtask

	task automatic set_en(input logic [13:0] v);
		i_alq_host.set_en(v);
		en = v;
		note_alarms();
	endtask

	task automatic sample(input logic [13:0] b);
		@(negedge clk_i);
		sample_valid = 1'b1;
		beyond = b;
		for (int i = 0; i < 14; i++)
			run[i] = b[i] ? ((run[i] < 16) ? run[i] + 1 : 16) : 0;
		@(negedge clk_i);
		sample_valid = 1'b0;
		lfsr = step(lfsr);
		beyond = lfsr[13:0]; // idle noise must not move the runs
		note_alarms();
	endtask

	// clean sample first so no run outlives its old length
	task automatic set_counts(input logic [31:0] v);
		set_en(14'h0);
		sample(14'h0);
		for (int k = 0; k < 4; k++)
			i_alq_host.access(1'b1, ALQ_OFF_OVERCUR + 8'(k), v[8 * k +: 8]);
		for (int k = 0; k < 4; k++)
			rd_chk(ALQ_OFF_OVERCUR + 8'(k), v[8 * k +: 8] & ((k == 0) ? 8'h0f : 8'hff));
		for (int c = 0; c < 4; c++) begin
			need[8 + c] = dec(v[15:8], c);
			need[4 + c] = dec(v[23:16], c);
			need[c] = dec(v[31:24], c);
		end
		need[12] = dec(v[7:0], 2);
		need[13] = dec(v[7:0], 3);
	endtask

	// watcher: oldest note against what just appeared
	always @(posedge clk_i) rd_pend <= rd;
	always @(negedge clk_i) begin
		if (rd_pend || alarm !== prev) begin
			if (q.size() == 0)
				check("unexpected", 14'h3fff, 14'h0);
			else
				check(qn.pop_front(), rd_pend ? {6'h0, rdata} : alarm, q.pop_front());
		end
		prev = alarm;
	end

	// watchdog
	initial begin
		repeat (40000) @(posedge clk_i);
		n_errors++;
		summarize();
	end

	// main sequence
	initial begin
		reset_n_i = 1'b0;
		sample_valid = 1'b0;
		beyond = 14'h0;
		en = 14'h0;
		exp_alarm = 14'h0;
		foreach (run[i]) begin
			run[i] = 0;
			need[i] = 1;
		end
		repeat (2) @(posedge clk_i);
		@(negedge clk_i);
		reset_n_i = 1'b1;
		for (int a = 0; a < 5; a++)
			rd_chk(ALQ_OFF_OVERCUR + 8'(a), 8'h00);
		repeat (8) begin
			lfsr = step(lfsr);
			set_counts(lfsr);
			lfsr = step(lfsr);
			set_en(lfsr[13:0] | lfsr[27:14]);
			repeat (60) begin
				lfsr = step(lfsr);
				sample(lfsr[13:0] | lfsr[20:7] | lfsr[31:18]);
			end
		end
		set_en(14'h0);
		repeat (4) @(negedge clk_i);
		summarize();
	end
endmodule

`default_nettype wire

// File: verilog/alq_pkg.sv
package alq_pkg;

	// register offsets
	localparam logic [7:0] ALQ_OFF_OVERCUR  = 8'h44;
	localparam logic [7:0] ALQ_OFF_UNDERCUR = 8'h45;
	localparam logic [7:0] ALQ_OFF_OVERPWR  = 8'h46;
	localparam logic [7:0] ALQ_OFF_OVERVOLT = 8'h47;

	// field layout: channel n (0 = ch1) sits at bits 7-2n : 6-2n
	localparam int          ALQ_FIELD_W   = 2;
	localparam int          ALQ_CH1_LSB   = 6;
	localparam int          ALQ_CHANNELS  = 4;
	localparam int          ALQ_OVERCUR_CH3_LSB = 2;
	localparam int          ALQ_OVERCUR_CH4_LSB = 0;
	localparam logic [7:0]  ALQ_OVERCUR_MASK    = 8'h0f;

	// reset values
	localparam logic [7:0]  ALQ_COUNT_RST = 8'h00;
	localparam logic [7:0]  ALQ_RDATA_RST = 8'h00;

	// sample counts per code
	localparam logic [1:0]  ALQ_CODE_1    = 2'h0;
	localparam logic [1:0]  ALQ_CODE_4    = 2'h1;
	localparam logic [1:0]  ALQ_CODE_8    = 2'h2;
	localparam logic [4:0]  ALQ_NEED_1    = 5'h01;
	localparam logic [4:0]  ALQ_NEED_4    = 5'h04;
	localparam logic [4:0]  ALQ_NEED_8    = 5'h08;
	localparam logic [4:0]  ALQ_NEED_16   = 5'h10;
	localparam logic [4:0]  ALQ_CNT_RST   = 5'h00;
	localparam logic [4:0]  ALQ_CNT_ONE   = 5'h01;

	// decode a two-bit count field into a run length
	function automatic logic [4:0] alq_need(input logic [1:0] code);
		unique case (code)
			ALQ_CODE_1: alq_need = ALQ_NEED_1;
			ALQ_CODE_4: alq_need = ALQ_NEED_4;
			ALQ_CODE_8: alq_need = ALQ_NEED_8;
			default:    alq_need = ALQ_NEED_16;
		endcase
	endfunction

endpackage

// File: verilog/alq_qual.sv
`timescale 1ns/1ps
`default_nettype none

module alq_qual
	import alq_pkg::*;
(
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       reset_n_i,
	// conversion result
	input  wire logic       sample_valid_i,
	input  wire logic       beyond_i,
	// run length setting
	input  wire logic [1:0] count_code_i,
	// qualified level
	output logic            alarm_o
);

	logic [4:0] cnt_q;
	logic [4:0] cnt_d;
	logic       alarm_q;
	logic       alarm_d;
	logic [4:0] need_w;
	logic [4:0] inc_w;

	assign need_w  = alq_need(count_code_i);
	assign alarm_o = alarm_q;

	// run counter; only a finished conversion may move or clear it
	always_comb begin
		cnt_d   = cnt_q;
		alarm_d = alarm_q;
		inc_w   = (cnt_q < need_w) ? 5'(cnt_q + ALQ_CNT_ONE) : cnt_q; // saturate at need
		if (sample_valid_i) begin
			if (beyond_i) begin
				cnt_d   = inc_w;
				alarm_d = (inc_w >= need_w);
			end else begin
				cnt_d   = ALQ_CNT_RST;
				alarm_d = 1'h0;
			end
		end
	end

	// counter state
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cnt_q   <= ALQ_CNT_RST;
			alarm_q <= 1'h0;
		end else begin
			cnt_q   <= cnt_d;
			alarm_q <= alarm_d;
		end
	end

	a_rise_on_beyond: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		$rose(alarm_q) |-> $past(sample_valid_i) && $past(beyond_i))
		else $error("alarm rose without a beyond sample");

	a_miss_clears_run: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		sample_valid_i && !beyond_i |=> !alarm_q && cnt_q == ALQ_CNT_RST)
		else $error("clean sample did not restart the run");

	a_idle_holds_run: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		!sample_valid_i |=> $stable(cnt_q) && $stable(alarm_q))
		else $error("run changed without a conversion");

	a_rise_full_run: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		$rose(alarm_q) |-> cnt_q >= $past(need_w) && cnt_q != ALQ_CNT_RST)
		else $error("alarm rose before the run length");

endmodule

`default_nettype wire

// File: verilog/alq_top.sv
`timescale 1ns/1ps
`default_nettype none

module alq_top
	import alq_pkg::*;
(
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       reset_n_i,
	// register access from the serial slave
	input  wire logic       reg_wr_i,
	input  wire logic       reg_rd_i,
	input  wire logic [7:0] reg_addr_i,
	input  wire logic [7:0] reg_wdata_i,
	output logic      [7:0] reg_rdata_o,
	// comparator results, bit 0 = channel 1; overcurrent bit 0 = ch3, bit 1 = ch4
	input  wire logic       sample_valid_i,
	input  wire logic [1:0] overcurrent_beyond_i,
	input  wire logic [3:0] undercurrent_beyond_i,
	input  wire logic [3:0] overpower_beyond_i,
	input  wire logic [3:0] overvoltage_beyond_i,
	// alarm enables, bit 0 = channel 1; overcurrent bit 0 = ch3, bit 1 = ch4
	input  wire logic [1:0] overcurrent_enable_i,
	input  wire logic [3:0] undercurrent_enable_i,
	input  wire logic [3:0] overpower_enable_i,
	input  wire logic [3:0] overvoltage_enable_i,
	// routed alarms; overcurrent bit 0 = ch3, bit 1 = ch4
	output logic      [1:0] overcurrent_alarm_o,
	output logic      [3:0] undercurrent_alarm_o,
	output logic      [3:0] overpower_alarm_o,
	output logic      [3:0] overvoltage_alarm_o
);

	logic [7:0] overcurrent_sample_count_q;
	logic [7:0] overcurrent_sample_count_d;
	logic [7:0] undercurrent_sample_count_q;
	logic [7:0] undercurrent_sample_count_d;
	logic [7:0] overpower_sample_count_q;
	logic [7:0] overpower_sample_count_d;
	logic [7:0] overvoltage_sample_count_q;
	logic [7:0] overvoltage_sample_count_d;
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;

	// register writes; upper overcurrent bits are not held here
	always_comb begin
		overcurrent_sample_count_d  = overcurrent_sample_count_q;
		undercurrent_sample_count_d = undercurrent_sample_count_q;
		overpower_sample_count_d    = overpower_sample_count_q;
		overvoltage_sample_count_d  = overvoltage_sample_count_q;
		if (reg_wr_i) begin
			unique case (reg_addr_i)
				ALQ_OFF_OVERCUR:  overcurrent_sample_count_d  = reg_wdata_i & ALQ_OVERCUR_MASK;
				ALQ_OFF_UNDERCUR: undercurrent_sample_count_d = reg_wdata_i;
				ALQ_OFF_OVERPWR:  overpower_sample_count_d    = reg_wdata_i;
				ALQ_OFF_OVERVOLT: overvoltage_sample_count_d  = reg_wdata_i;
				default: ;
			endcase
		end
	end

	// read data is registered; unmapped offsets read zero
	always_comb begin
		rdata_d = rdata_q;
		if (reg_rd_i) begin
			unique case (reg_addr_i)
				ALQ_OFF_OVERCUR:  rdata_d = overcurrent_sample_count_q;
				ALQ_OFF_UNDERCUR: rdata_d = undercurrent_sample_count_q;
				ALQ_OFF_OVERPWR:  rdata_d = overpower_sample_count_q;
				ALQ_OFF_OVERVOLT: rdata_d = overvoltage_sample_count_q;
				default:    rdata_d = ALQ_RDATA_RST;
			endcase
		end
	end

	// register file
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			overcurrent_sample_count_q  <= ALQ_COUNT_RST;
			undercurrent_sample_count_q <= ALQ_COUNT_RST;
			overpower_sample_count_q    <= ALQ_COUNT_RST;
			overvoltage_sample_count_q  <= ALQ_COUNT_RST;
			rdata_q                     <= ALQ_RDATA_RST;
		end else begin
			overcurrent_sample_count_q  <= overcurrent_sample_count_d;
			undercurrent_sample_count_q <= undercurrent_sample_count_d;
			overpower_sample_count_q    <= overpower_sample_count_d;
			overvoltage_sample_count_q  <= overvoltage_sample_count_d;
			rdata_q                     <= rdata_d;
		end
	end

	assign reg_rdata_o = rdata_q;

	logic [1:0] overcur_qual_w;
	logic [3:0] undercur_qual_w;
	logic [3:0] overpwr_qual_w;
	logic [3:0] overvolt_qual_w;

	// one qualifier per channel and type, each on its own field and sample
	for (genvar c = 0; c < ALQ_CHANNELS; c++) begin : g_ch
		localparam int LSB = ALQ_CH1_LSB - ALQ_FIELD_W * c;

		alq_qual u_undercur (
			.clk_i          (clk_i),
			.reset_n_i      (reset_n_i),
			.sample_valid_i (sample_valid_i),
			.beyond_i       (undercurrent_beyond_i[c]),
			.count_code_i   (undercurrent_sample_count_q[LSB +: ALQ_FIELD_W]),
			.alarm_o        (undercur_qual_w[c])
		);

		alq_qual u_overpwr (
			.clk_i          (clk_i),
			.reset_n_i      (reset_n_i),
			.sample_valid_i (sample_valid_i),
			.beyond_i       (overpower_beyond_i[c]),
			.count_code_i   (overpower_sample_count_q[LSB +: ALQ_FIELD_W]),
			.alarm_o        (overpwr_qual_w[c])
		);

		alq_qual u_overvolt (
			.clk_i          (clk_i),
			.reset_n_i      (reset_n_i),
			.sample_valid_i (sample_valid_i),
			.beyond_i       (overvoltage_beyond_i[c]),
			.count_code_i   (overvoltage_sample_count_q[LSB +: ALQ_FIELD_W]),
			.alarm_o        (overvolt_qual_w[c])
		);
	end

	// overcurrent exists for channels 3 and 4 only in this block
	alq_qual u_overcur3 (
		.clk_i          (clk_i),
		.reset_n_i      (reset_n_i),
		.sample_valid_i (sample_valid_i),
		.beyond_i       (overcurrent_beyond_i[0]),
		.count_code_i   (overcurrent_sample_count_q[ALQ_OVERCUR_CH3_LSB +: ALQ_FIELD_W]),
		.alarm_o        (overcur_qual_w[0])
	);

	alq_qual u_overcur4 (
		.clk_i          (clk_i),
		.reset_n_i      (reset_n_i),
		.sample_valid_i (sample_valid_i),
		.beyond_i       (overcurrent_beyond_i[1]),
		.count_code_i   (overcurrent_sample_count_q[ALQ_OVERCUR_CH4_LSB +: ALQ_FIELD_W]),
		.alarm_o        (overcur_qual_w[1])
	);

	logic [1:0] overcur_alarm_q;
	logic [1:0] overcur_alarm_d;
	logic [3:0] undercur_alarm_q;
	logic [3:0] undercur_alarm_d;
	logic [3:0] overpwr_alarm_q;
	logic [3:0] overpwr_alarm_d;
	logic [3:0] overvolt_alarm_q;
	logic [3:0] overvolt_alarm_d;

	// enable gating; a disabled alarm keeps qualifying but is not routed
	always_comb begin
		overcur_alarm_d  = overcur_qual_w & overcurrent_enable_i;
		undercur_alarm_d = undercur_qual_w & undercurrent_enable_i;
		overpwr_alarm_d  = overpwr_qual_w & overpower_enable_i;
		overvolt_alarm_d = overvolt_qual_w & overvoltage_enable_i;
	end

	// routed alarm flops
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			overcur_alarm_q  <= 2'h0;
			undercur_alarm_q <= 4'h0;
			overpwr_alarm_q  <= 4'h0;
			overvolt_alarm_q <= 4'h0;
		end else begin
			overcur_alarm_q  <= overcur_alarm_d;
			undercur_alarm_q <= undercur_alarm_d;
			overpwr_alarm_q  <= overpwr_alarm_d;
			overvolt_alarm_q <= overvolt_alarm_d;
		end
	end

	assign overcurrent_alarm_o  = overcur_alarm_q;
	assign undercurrent_alarm_o = undercur_alarm_q;
	assign overpower_alarm_o    = overpwr_alarm_q;
	assign overvoltage_alarm_o  = overvolt_alarm_q;

	a_reset_fields_zero: assert property (@(posedge clk_i)
		!reset_n_i |-> undercurrent_sample_count_q == ALQ_COUNT_RST
			&& overpower_sample_count_q == ALQ_COUNT_RST
			&& overvoltage_sample_count_q == ALQ_COUNT_RST
			&& overcurrent_sample_count_q == ALQ_COUNT_RST)
		else $error("count field not zero in reset");

	a_count_write_store: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		reg_wr_i && reg_addr_i == ALQ_OFF_UNDERCUR
			|=> undercurrent_sample_count_q == $past(reg_wdata_i))
		else $error("undercurrent count write lost");

	a_overcur_low_only: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		(overcurrent_sample_count_q & ~ALQ_OVERCUR_MASK) == ALQ_COUNT_RST)
		else $error("overcurrent count holds unused bits");

	a_enable_gates_out: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		##1 (undercur_alarm_q & ~$past(undercurrent_enable_i)) == 4'h0
			&& (overpwr_alarm_q & ~$past(overpower_enable_i)) == 4'h0
			&& (overvolt_alarm_q & ~$past(overvoltage_enable_i)) == 4'h0
			&& (overcur_alarm_q & ~$past(overcurrent_enable_i)) == 2'h0)
		else $error("alarm routed while disabled");

endmodule

`default_nettype wire
